// File: hdl/assr_pkg.sv
package assr_pkg;

    // ==========================================================
    // Sample carrier and sizes
    // ==========================================================
    localparam int SAMPLE_BITS = 10;
    localparam int AXES = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int LOW_PAD_BITS = 6;

    typedef struct packed {
        logic [1:0] axis;
        logic [SAMPLE_BITS-1:0] value;
    } assr_sample_t;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH = 8'h01;
    localparam logic [7:0] ADDR_Z_LOW = 8'h06;
    localparam logic [7:0] ADDR_PRIMARY_CONTROL = 8'h2A;
    localparam logic [7:0] ADDR_RESET = 8'h00;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_FAST_READ = 1;
    localparam int BIT_ALL_OVERWRITE = 7;
    localparam int BIT_OVERWRITE_BASE = 4;
    localparam int BIT_ALL_READY = 3;
    localparam int BIT_READY_BASE = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // Serial slave states
    // ==========================================================
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_DEV_ADDR = 9'h002,
        ST_DEV_ACK = 9'h004,
        ST_REG_ADDR = 9'h008,
        ST_REG_ACK = 9'h010,
        ST_WR_DATA = 9'h020,
        ST_WR_ACK = 9'h040,
        ST_RD_DATA = 9'h080,
        ST_RD_ACK = 9'h100
    } assr_state_t;

    // ==========================================================
    // Address helpers
    // ==========================================================
    // Burst step; fast mode skips the low bytes of the data range
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast);
        logic skip;
        skip = fast && (a == 8'h01 || a == 8'h03 || a == 8'h05);
        next_addr = skip ? a + 8'h02 : a + 8'h01;
    endfunction

    // True when the address lies in the sample data range
    function automatic logic in_data(input logic [7:0] a);
        in_data = (a >= ADDR_X_HIGH) && (a <= ADDR_Z_LOW);
    endfunction

endpackage

// File: hdl/assr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module assr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshakes
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, fill level and registered ready
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
                in_ready <= (count + 1'b1) != (AW+1)'(DEPTH);
            end else if (pop && !push) begin
                count <= count - 1'b1;
                in_ready <= 1'b1;
            end else begin
                in_ready <= count != (AW+1)'(DEPTH);
            end
        end
    end
endmodule // assr_fifo
`default_nettype wire

// File: hdl/assr_regs.sv
// Summary of operation
// - Axis ready flag sets on a new sample, clears on its high byte read.
// - Axis overwrite flag sets on a sample over an unread one, clears on its high read.
// - Combined ready flag, status bit 3, sets on any new sample.
// - Combined ready flag clears once all three high bytes are read, and on entry to active mode.
// - Combined overwrite flag, status bit 7, sets on any overwrite.
// - Combined overwrite flag clears once all three high bytes are read since it set.
// - All eight flags reset to zero; the status byte is read-only.
// - Samples are 10-bit two's complement: high byte bits 9..2, low byte bits 1..0 then zeros.
// - Samples sit at 0x01..0x06, so a burst from status takes seven bytes.
// - With fast read (0x2A bit 1) the burst skips low bytes, four bytes in all.
// - A low byte reads back only right after its own high byte.
// - A high byte and the low byte after it come from one sample.
// - The address steps only inside a burst read.
// - The held address returns to zero on a bus STOP.
// - Samples and flags are kept only in active mode.
`timescale 1ns/1ps
`default_nettype none
module assr_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2C // Arbitrary bus address
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Sample strobes from the conversion path
    input wire logic sample_valid,
    input wire assr_pkg::assr_sample_t sample_in,
    output logic sample_ready,
    // Mode
    output logic active_mode
);
    // ==========================================================
    // Declarations
    // ==========================================================
    localparam int SW = $bits(assr_pkg::assr_sample_t);

    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    assr_pkg::assr_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in, tx_shift, ptr, control, low_snap, rd_addr, load_addr, load_byte;
    logic rw_bit, host_ack, bus_busy, snap_valid, rd_strobe, active_q, load_now;
    logic [1:0] snap_axis;
    logic [assr_pkg::SAMPLE_BITS-1:0] sample [assr_pkg::AXES];
    logic [2:0] ready_flag, overwrite_flag, seen_ready, seen_overwrite;
    logic [2:0] new_hit, ow_hit, high_hit;
    logic all_ready_flag, all_overwrite_flag, fifo_valid, fifo_ready;
    logic [SW-1:0] fifo_data;
    assr_pkg::assr_sample_t drained;

    // ==========================================================
    // Sample buffering
    // ==========================================================
    // Queue stalls during bus transfers
    assign fifo_ready = !bus_busy;
    assign drained = assr_pkg::assr_sample_t'(fifo_data);

    assr_fifo #(
        .WIDTH(SW),
        .DEPTH(assr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_in),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // ==========================================================
    // Pin synchronisers and bus events
    // ==========================================================
    // Two stages before use, third for edge finding
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3f;
        end else begin
            {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_in};
            {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_in};
        end
    end

    // Edges and start/stop conditions
    assign scl_rise = scl_s2 && !scl_s3;
    assign scl_fall = !scl_s2 && scl_s3;
    assign start_seen = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
    assign stop_seen = scl_s2 && scl_s3 && sda_s2 && !sda_s3;

    // ==========================================================
    // Read data selection
    // ==========================================================
    // Address of the byte about to be shifted out
    always_comb begin
        load_now = 1'b0;
        load_addr = ptr;
        if (scl_fall && state == assr_pkg::ST_DEV_ACK && rw_bit) begin
            load_now = 1'b1;
        end else if (scl_fall && state == assr_pkg::ST_RD_ACK && host_ack) begin
            load_now = 1'b1;
            load_addr = assr_pkg::next_addr(ptr, control[assr_pkg::BIT_FAST_READ]);
        end
    end

    // Byte presented for the selected address
    always_comb begin
        load_byte = 8'h00;
        if (load_addr == assr_pkg::ADDR_STATUS) begin
            load_byte = {all_overwrite_flag, overwrite_flag, all_ready_flag, ready_flag};
        end else if (load_addr == assr_pkg::ADDR_PRIMARY_CONTROL) begin
            load_byte = control;
        end else if (assr_pkg::in_data(load_addr)) begin
            if (load_addr[0]) begin
                // High bytes at odd offsets
                load_byte = sample[2'((load_addr - 8'h01) >> 1)][9:2];
            end else if (snap_valid && snap_axis == 2'((load_addr - 8'h02) >> 1)) begin
                load_byte = low_snap;
            end
        end
    end

    // ==========================================================
    // Serial slave
    // ==========================================================
    // Byte engine
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= assr_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            tx_shift <= 8'h00;
            ptr <= assr_pkg::ADDR_RESET;
            rw_bit <= 1'b0;
            host_ack <= 1'b0;
            sda_oe <= 1'b0;
            control <= assr_pkg::CONTROL_RESET;
        end else if (stop_seen) begin
            state <= assr_pkg::ST_IDLE;
            ptr <= assr_pkg::ADDR_RESET;
            sda_oe <= 1'b0;
        end else if (start_seen) begin
            state <= assr_pkg::ST_DEV_ADDR;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            case (state)
                assr_pkg::ST_DEV_ADDR, assr_pkg::ST_REG_ADDR, assr_pkg::ST_WR_DATA: begin
                    shift_in <= {shift_in[6:0], sda_s2};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                assr_pkg::ST_RD_ACK: begin
                    host_ack <= !sda_s2;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                assr_pkg::ST_DEV_ADDR: begin
                    if (bit_cnt == assr_pkg::BITS_PER_BYTE) begin
                        if (shift_in[7:1] == DEV_ADDR) begin
                            state <= assr_pkg::ST_DEV_ACK;
                            rw_bit <= shift_in[0];
                            sda_oe <= 1'b1;
                        end else begin
                            state <= assr_pkg::ST_IDLE;
                        end
                    end
                end
                assr_pkg::ST_DEV_ACK: begin
                    bit_cnt <= 4'h0;
                    if (rw_bit) begin
                        state <= assr_pkg::ST_RD_DATA;
                        tx_shift <= {load_byte[6:0], 1'b0};
                        sda_oe <= !load_byte[7];
                        bit_cnt <= 4'h1;
                    end else begin
                        state <= assr_pkg::ST_REG_ADDR;
                        sda_oe <= 1'b0;
                    end
                end
                assr_pkg::ST_REG_ADDR: begin
                    if (bit_cnt == assr_pkg::BITS_PER_BYTE) begin
                        state <= assr_pkg::ST_REG_ACK;
                        ptr <= shift_in;
                        sda_oe <= 1'b1;
                    end
                end
                assr_pkg::ST_REG_ACK, assr_pkg::ST_WR_ACK: begin
                    state <= assr_pkg::ST_WR_DATA;
                    bit_cnt <= 4'h0;
                    sda_oe <= 1'b0;
                end
                assr_pkg::ST_WR_DATA: begin
                    if (bit_cnt == assr_pkg::BITS_PER_BYTE) begin
                        state <= assr_pkg::ST_WR_ACK;
                        sda_oe <= 1'b1;
                        if (ptr == assr_pkg::ADDR_PRIMARY_CONTROL) begin
                            control <= shift_in;
                        end
                    end
                end
                assr_pkg::ST_RD_DATA: begin
                    if (bit_cnt == assr_pkg::BITS_PER_BYTE) begin
                        state <= assr_pkg::ST_RD_ACK;
                        sda_oe <= 1'b0;
                    end else begin
                        sda_oe <= !tx_shift[7];
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                assr_pkg::ST_RD_ACK: begin
                    if (host_ack) begin
                        state <= assr_pkg::ST_RD_DATA;
                        ptr <= load_addr;
                        tx_shift <= {load_byte[6:0], 1'b0};
                        sda_oe <= !load_byte[7];
                        bit_cnt <= 4'h1;
                    end else begin
                        state <= assr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= assr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Bus busy between start and stop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus_busy <= 1'b0;
        end else if (stop_seen) begin
            bus_busy <= 1'b0;
        end else if (start_seen) begin
            bus_busy <= 1'b1;
        end
    end

    // Read access record and low byte snapshot
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_strobe <= 1'b0;
            rd_addr <= 8'h00;
            low_snap <= 8'h00;
            snap_axis <= 2'h0;
            snap_valid <= 1'b0;
        end else begin
            rd_strobe <= load_now;
            if (load_now) begin
                rd_addr <= load_addr;
                // Low byte only readable right after its high byte
                snap_valid <= assr_pkg::in_data(load_addr) && load_addr[0];
                snap_axis <= 2'((load_addr - 8'h01) >> 1);
                low_snap <= {sample[2'((load_addr - 8'h01) >> 1)][1:0],
                             {assr_pkg::LOW_PAD_BITS{1'b0}}};
            end else if (stop_seen) begin
                snap_valid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sample registers and flags
    // ==========================================================
    // Per-axis events for this cycle
    always_comb begin
        new_hit = 3'h0;
        ow_hit = 3'h0;
        high_hit = 3'h0;
        for (int a = 0; a < assr_pkg::AXES; a++) begin
            new_hit[a] = fifo_valid && fifo_ready && active_mode
                         && drained.axis == 2'(a);
            ow_hit[a] = new_hit[a] && ready_flag[a];
            high_hit[a] = rd_strobe && rd_addr == 8'(2 * a + 1);
        end
    end

    // Mode follows the control register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {active_q, active_mode} <= 2'h0;
        end else begin
            {active_q, active_mode} <= {active_mode, control[assr_pkg::BIT_ACTIVE]};
        end
    end

    // Output samples
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sample <= '{default: '0};
        end else begin
            for (int a = 0; a < assr_pkg::AXES; a++) begin
                if (new_hit[a]) begin
                    sample[a] <= drained.value;
                end
            end
        end
    end

    // Per-axis flags, set beats clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ready_flag <= 3'h0;
            overwrite_flag <= 3'h0;
        end else if (active_mode && !active_q) begin
            ready_flag <= 3'h0;
            overwrite_flag <= 3'h0;
        end else begin
            ready_flag <= new_hit | (ready_flag & ~high_hit);
            overwrite_flag <= ow_hit | (overwrite_flag & ~high_hit);
        end
    end

    // Combined flags, cleared once all high bytes are read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            all_ready_flag <= 1'b0;
            all_overwrite_flag <= 1'b0;
            seen_ready <= 3'h0;
            seen_overwrite <= 3'h0;
        end else if (active_mode && !active_q) begin
            all_ready_flag <= 1'b0;
            all_overwrite_flag <= 1'b0;
            seen_ready <= 3'h0;
            seen_overwrite <= 3'h0;
        end else begin
            if (|new_hit) begin
                all_ready_flag <= 1'b1;
            end else if (&(seen_ready | high_hit)) begin
                all_ready_flag <= 1'b0;
            end
            seen_ready <= (&(seen_ready | high_hit)) ? 3'h0 : (seen_ready | high_hit);
            if (|ow_hit) begin
                all_overwrite_flag <= 1'b1;
                seen_overwrite <= 3'h0;
            end else if (&(seen_overwrite | high_hit)) begin
                all_overwrite_flag <= 1'b0;
                seen_overwrite <= 3'h0;
            end else begin
                seen_overwrite <= seen_overwrite | high_hit;
            end
        end
    end
endmodule // assr_regs
`default_nettype wire

// File: test/assr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial bus host model
// ==========================================================
module assr_host (
    // Wire level
    input wire logic sda_wire,
    // Host lines, sda_drv high releases the wire
    output logic scl,
    output logic sda_drv
);
    // Lines released, clock high between frames
    initial begin
        scl = 1'h1;
        sda_drv = 1'h1;
    end
    // One bit: data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        #31 scl = 1'h1;
        #31 r = sda_wire;
        #31 scl = 1'h0;
        #32;
    endtask
    // Start or repeated start
    task automatic start();
        sda_drv = 1'h1;
        #31 scl = 1'h1;
        #31 sda_drv = 1'h0;
        #31 scl = 1'h0;
        #32;
    endtask
    // Stop, then both lines stay released
    task automatic stop();
        sda_drv = 1'h0;
        #31 scl = 1'h1;
        #31 sda_drv = 1'h1;
        #63;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic k, output logic [7:0] q,
                           output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(k, a);
    endtask
endmodule // assr_host
`default_nettype wire

// File: test/assr_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks for the register block
// ==========================================================
module assr_regs_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Bus and sample pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic sample_valid,
    input wire assr_pkg::assr_sample_t sample_in,
    input wire logic sample_ready,
    input wire logic active_mode
);
    default clocking cb @(posedge core_clk); endclocking
    // Reset and sample path
    property p_rst_quiet;
        !rstn |-> !sda_oe && !sample_ready && !active_mode;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output active in reset");
    property p_rdy_up;
        disable iff (!rstn) $rose(rstn) |=> sample_ready;
    endproperty
    a_rdy_up: assert property (p_rdy_up) else $error("queue not ready after reset");
    property p_rdy_fall;
        disable iff (!rstn) $fell(sample_ready) |-> $past(sample_valid);
    endproperty
    a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell with no offer");
    // Serial line timing
    property p_out_low;
        disable iff (!rstn) sda_out == 1'h0;
    endproperty
    a_out_low: assert property (p_out_low) else $error("data drive value not low");
    property p_oe_moves;
        disable iff (!rstn) $changed(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2);
    endproperty
    a_oe_moves: assert property (p_oe_moves) else $error("drive moved near clock high");
    property p_oe_hold;
        disable iff (!rstn) $rose(scl_in) |-> $stable(sda_oe) [*5];
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("drive moved in clock high");
    property p_stop_rel;
        disable iff (!rstn) scl_in && $rose(sda_in) |=> !sda_oe [*4];
    endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("line driven after stop");
    property p_start_rel;
        disable iff (!rstn) scl_in && $fell(sda_in) |=> !sda_oe [*4];
    endproperty
    a_start_rel: assert property (p_start_rel) else $error("line driven after start");
    // Main scenarios reached
    c_full: cover property (disable iff (!rstn) $fell(sample_ready));
    c_drive: cover property (disable iff (!rstn) $rose(sda_oe));
    c_active: cover property (disable iff (!rstn) $rose(active_mode));
endmodule // assr_regs_sva
`default_nettype wire

// File: test/assr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register block bench
// ==========================================================
module assr_regs_tb;
    localparam logic [6:0] DEV = 7'h2c; // Arbitrary bus address
    logic core_clk, rstn, sample_valid, sample_ready, active_mode;
    logic scl, sda_drv, sda_wire, sda_out, sda_oe, nak, took, fast, all_r, all_o;
    assr_pkg::assr_sample_t sample_in;
    logic [9:0] val [3];
    logic [2:0] rdy, ow, seen_r, seen_o;
    logic [7:0] q, ctrl;
    logic [31:0] rv;
    int failures, checks, seed, cnt, n, op;
    // Open-drain wire with pull-up
    assign sda_wire = (sda_oe ? sda_out : 1'h1) & sda_drv;
    assr_regs #(.DEV_ADDR(DEV)) assr_regs_inst (.core_clk(core_clk), .rstn(rstn),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .sample_valid(sample_valid), .sample_in(sample_in), .sample_ready(sample_ready),
        .active_mode(active_mode));
    assr_host assr_host_inst (.sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
    // Core clock
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic finish_test();
        if (failures == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Offer one sample; model takes it if accepted
    task automatic push(input logic [11:0] s);
        logic [1:0] x;
        x = s[11:10];
        @(negedge core_clk);
        sample_valid = 1'h1;
        sample_in = s;
        took = sample_ready;
        cnt = cnt + took;
        if (took && x != 2'h3) begin
            all_o = all_o | rdy[x];
            seen_o = rdy[x] ? 3'h0 : seen_o;
            ow[x] = ow[x] | rdy[x];
            rdy[x] = 1'h1;
            all_r = 1'h1;
            val[x] = s[9:0];
        end
    endtask
    // Expected byte at an address, with read clears
    function automatic logic [7:0] exp_at(input logic [7:0] a, input logic [7:0] p);
        int x;
        x = (a - 8'h01) >> 1;
        exp_at = 8'h00;
        if (a == 8'h00) begin
            exp_at = {all_o, ow, all_r, rdy};
        end else if (a == 8'h2a) begin
            exp_at = ctrl;
        end else if (a < 8'h07 && a[0]) begin
            exp_at = val[x][9:2];
            rdy[x] = 1'h0;
            ow[x] = 1'h0;
            seen_r[x] = 1'h1;
            seen_o[x] = 1'h1;
            all_r = all_r & ~&seen_r;
            all_o = all_o & ~&seen_o;
            seen_r = (&seen_r) ? 3'h0 : seen_r;
            seen_o = (&seen_o) ? 3'h0 : seen_o;
        end else if (a < 8'h07 && p == a - 8'h01) begin
            exp_at = {val[x][1:0], 6'h00};
        end
    endfunction
    // Optional pointer write, then nb checked reads
    task automatic rd(input int ra, input int nb);
        logic [7:0] a;
        logic [7:0] p;
        a = (ra < 0) ? 8'h00 : ra[7:0];
        p = 8'hff;
        if (ra >= 0) begin
            assr_host_inst.start();
            assr_host_inst.byte_io({DEV, 1'h0}, 1'h1, q, nak);
            assr_host_inst.byte_io(a, 1'h1, q, nak);
        end
        assr_host_inst.start();
        assr_host_inst.byte_io({DEV, 1'h1}, 1'h1, q, nak);
        for (int i = 0; i < nb; i++) begin
            assr_host_inst.byte_io(8'hff, i == nb - 1, q, nak);
            check(q, exp_at(a, p));
            p = a;
            a = a + ((fast && a[0] && a < 8'h06) ? 8'h02 : 8'h01);
        end
        assr_host_inst.stop();
    endtask
    // Control register write
    task automatic wr_ctrl(input logic [7:0] d);
        assr_host_inst.start();
        assr_host_inst.byte_io({DEV, 1'h0}, 1'h1, q, nak);
        assr_host_inst.byte_io(assr_pkg::ADDR_PRIMARY_CONTROL, 1'h1, q, nak);
        assr_host_inst.byte_io(d, 1'h1, q, nak);
        assr_host_inst.stop();
        ctrl = d;
        fast = d[1];
    endtask
    // Main sequence
    initial begin
        {seed, failures, checks, cnt} = {32'd33385, 96'h0};
        {rdy, ow, seen_r, seen_o, all_r, all_o, fast, rstn, sample_valid} = '0;
        sample_in = '0;
        repeat (3) @(negedge core_clk);
        rstn = 1'h1;
        repeat (2) @(negedge core_clk);
        rd(-1, 1);
        wr_ctrl(8'h01);
        check({7'h00, active_mode}, 8'h01);
        rd(32'h0000_002a, 1);
        assr_host_inst.start();
        assr_host_inst.byte_io({7'h2d, 1'h0}, 1'h1, q, nak);
        assr_host_inst.stop();
        check({7'h00, nak}, 8'h01);
        assr_host_inst.start();
        for (int i = 0; i < 20; i++) begin
            rv = $random(seed);
            push({2'(i % 3), rv[9:0]});
        end
        @(negedge core_clk) sample_valid = 1'h0;
        check(cnt[7:0], 8'h10);
        assr_host_inst.stop();
        repeat (40) @(posedge core_clk);
        for (int r = 0; r < 14; r++) begin
            rv = $random(seed);
            n = rv[2:0];
            op = rv[5:4];
            for (int i = 0; i < n; i++) begin
                rv = $random(seed);
                push(rv[11:0]);
            end
            @(negedge core_clk) sample_valid = 1'h0;
            repeat (20) @(posedge core_clk);
            if (op < 2 && op[0] != fast) wr_ctrl({6'h00, op[0], 1'h1});
            if (op < 2) rd(-1, fast ? 4 : 7);
            else if (op == 2) rd(int'(rv[7:6]) * 2 + 1, 1);
            else begin
                rd(-1, 1);
                rd(int'(rv[7:6]) * 2 + 2, 1);
            end
        end
        finish_test();
    end
    // Hang guard
    initial begin
        #390000;
        failures++;
        finish_test();
    end
endmodule // assr_regs_tb
bind assr_regs assr_regs_sva assr_regs_sva_inst (.core_clk(core_clk), .rstn(rstn),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .sample_valid(sample_valid), .sample_in(sample_in), .sample_ready(sample_ready),
    .active_mode(active_mode));
`default_nettype wire
